/* File: logic/capability_pkg.sv */
// constants for the feature capability register block
package capability_pkg;

    // =========================================================
    // register map
    // =========================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] FEATURE_CAPABILITY_FLAGS_IDX = 8'h02;
    localparam logic [DATA_W-1:0] FEATURE_CAPABILITY_FLAGS_RESET = 32'h000006c3;

    // =========================================================
    // field positions
    // =========================================================
    localparam int TX_FCS_CHECK_CAP_BIT = 10;
    localparam int INDIRECT_PHY_ACCESS_CAP_BIT = 9;
    localparam int DIRECT_PHY_ACCESS_CAP_BIT = 8;
    localparam int CUT_THROUGH_CAP_BIT = 7;
    localparam int FRAME_TIMESTAMP_CAP_BIT = 6;
    localparam int ADDR_INCR_DISABLE_CAP_BIT = 5;
    localparam int TX_CHUNK_RETRY_CAP_BIT = 4;
    localparam int RESERVED_LOW_BIT = 3;
    localparam int MIN_CHUNK_PAYLOAD_EXP_LSB = 0;
    localparam int MIN_CHUNK_PAYLOAD_EXP_W = 3;
    localparam int RESERVED_HIGH_LSB = 11;

    // =========================================================
    // field reset values
    // =========================================================
    localparam logic TX_FCS_CHECK_CAP_RESET = 1'h1;
    localparam logic INDIRECT_PHY_ACCESS_CAP_RESET = 1'h1;
    localparam logic DIRECT_PHY_ACCESS_CAP_RESET = 1'h0;
    localparam logic CUT_THROUGH_CAP_RESET = 1'h1;
    localparam logic FRAME_TIMESTAMP_CAP_RESET = 1'h1;
    localparam logic ADDR_INCR_DISABLE_CAP_RESET = 1'h0;
    localparam logic TX_CHUNK_RETRY_CAP_RESET = 1'h0;
    localparam logic [MIN_CHUNK_PAYLOAD_EXP_W-1:0] MIN_CHUNK_PAYLOAD_EXP_RESET = 3'h3;

    // =========================================================
    // access sequencing
    // =========================================================
    typedef enum logic [0:0] {
        ACC_IDLE,
        ACC_ANSWER
    } acc_state_t;

endpackage

/* File: logic/min_chunk_guard.sv */
// watches host chunk payload size programming against the advertised minimum
`timescale 1ns/1ps

module min_chunk_guard #(
    parameter int EXP_W = 3
) (
    input wire logic clk, // register clock
    input wire logic rst_n, // async reset, active low
    input wire logic [EXP_W-1:0] minExp, // advertised minimum exponent
    input wire logic [EXP_W-1:0] cpsField, // exponent the host programmed
    input wire logic cpsWrite, // one-cycle strobe: new value written
    output logic belowMin // last programmed size is too small
);

    logic belowMin_reg;
    logic belowMin_next;
    logic tooSmall;

    // =========================================================
    // compare and hold
    // =========================================================
    // unsigned compare: a larger exponent is always a larger payload
    assign tooSmall = cpsField < minExp;
    // flag follows every write, holds between writes
    assign belowMin_next = cpsWrite ? tooSmall : belowMin_reg;

    // level is kept so firmware bugs stay visible after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            belowMin_reg <= 1'b0;
        end
        else
        begin
            belowMin_reg <= belowMin_next;
        end
    end

    assign belowMin = belowMin_reg;

endmodule

/* File: logic/feature_capability_regs.sv */
// read-only feature capability register with its register access port
`timescale 1ns/1ps

module feature_capability_regs
    import capability_pkg::*;
#(
    parameter logic [capability_pkg::MIN_CHUNK_PAYLOAD_EXP_W-1:0] MIN_EXP =
        capability_pkg::MIN_CHUNK_PAYLOAD_EXP_RESET
) (
    input wire logic clk, // register clock, 250 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic regAccess, // access request strobe
    input wire logic regWrite, // 1 write, 0 read
    input wire logic [capability_pkg::ADDR_W-1:0] regAddr, // register index
    input wire logic [capability_pkg::DATA_W-1:0] regWdata, // write data
    output logic regReady, // request can be taken this cycle
    output logic regDone, // one-cycle answer pulse
    output logic regHit, // with regDone: address was mapped
    output logic [capability_pkg::DATA_W-1:0] regRdata, // read data, valid with regDone
    input wire logic [capability_pkg::MIN_CHUNK_PAYLOAD_EXP_W-1:0] cpsField, // host chunk size
    input wire logic cpsWrite, // strobe: chunk size field written
    output logic cpsBelowMin, // programmed chunk size under minimum
    output logic txFcsCheckCap, // fcs validation capability
    output logic indirectPhyAccessCap, // phy reachable indirectly
    output logic directPhyAccessCap, // phy mapped directly
    output logic cutThroughCap, // cut-through forwarding
    output logic frameTimestampCap, // time stamp capture
    output logic addrIncrDisableCap, // increment can be switched off
    output logic txChunkRetryCap, // chunk sequence and retry
    output logic [capability_pkg::MIN_CHUNK_PAYLOAD_EXP_W-1:0] minChunkPayloadExp // min exponent
);

    import capability_pkg::*;

    // =========================================================
    // declarations
    // =========================================================
    acc_state_t accState_reg;
    acc_state_t accState_next;
    logic [DATA_W-1:0] capWord;
    logic [DATA_W-1:0] capMasked;
    logic [DATA_W-1:0] cap_reg;
    logic [DATA_W-1:0] cap_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic hit_reg;
    logic hit_next;
    logic done_reg;
    logic done_next;
    logic taken;
    logic addrIsCap;
    logic [DATA_W-1:0] readMux;
    logic [DATA_W-1:0] writeSeen;

    // =========================================================
    // capability word assembly
    // =========================================================
    // fields placed at their fixed positions
    assign capWord[DATA_W-1:RESERVED_HIGH_LSB] = '0;
    assign capWord[TX_FCS_CHECK_CAP_BIT] = TX_FCS_CHECK_CAP_RESET;
    assign capWord[INDIRECT_PHY_ACCESS_CAP_BIT] = INDIRECT_PHY_ACCESS_CAP_RESET;
    assign capWord[DIRECT_PHY_ACCESS_CAP_BIT] = DIRECT_PHY_ACCESS_CAP_RESET;
    assign capWord[CUT_THROUGH_CAP_BIT] = CUT_THROUGH_CAP_RESET;
    assign capWord[FRAME_TIMESTAMP_CAP_BIT] = FRAME_TIMESTAMP_CAP_RESET;
    assign capWord[ADDR_INCR_DISABLE_CAP_BIT] = ADDR_INCR_DISABLE_CAP_RESET;
    assign capWord[TX_CHUNK_RETRY_CAP_BIT] = TX_CHUNK_RETRY_CAP_RESET;
    assign capWord[RESERVED_LOW_BIT] = 1'b0;
    assign capWord[MIN_CHUNK_PAYLOAD_EXP_LSB +: MIN_CHUNK_PAYLOAD_EXP_W] = MIN_EXP;

    // reserved bits forced low per bit, so a bad parameter cannot leak into them
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++)
        begin : g_mask
            if (gi >= RESERVED_HIGH_LSB || gi == RESERVED_LOW_BIT)
            begin : g_rsvd
                assign capMasked[gi] = 1'b0;
            end
            else
            begin : g_field
                assign capMasked[gi] = capWord[gi];
            end
        end
    endgenerate

    // =========================================================
    // capability holding register
    // =========================================================
    // the word is held in flops so the field outputs come from registers;
    // no write path exists, the next value is the constant itself
    assign cap_next = capMasked;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cap_reg <= FEATURE_CAPABILITY_FLAGS_RESET;
        end
        else
        begin
            cap_reg <= cap_next;
        end
    end

    // =========================================================
    // field outputs to the rest of the device
    // =========================================================
    assign txFcsCheckCap = cap_reg[TX_FCS_CHECK_CAP_BIT];
    assign indirectPhyAccessCap = cap_reg[INDIRECT_PHY_ACCESS_CAP_BIT];
    assign directPhyAccessCap = cap_reg[DIRECT_PHY_ACCESS_CAP_BIT];
    assign cutThroughCap = cap_reg[CUT_THROUGH_CAP_BIT];
    assign frameTimestampCap = cap_reg[FRAME_TIMESTAMP_CAP_BIT];
    assign addrIncrDisableCap = cap_reg[ADDR_INCR_DISABLE_CAP_BIT];
    assign txChunkRetryCap = cap_reg[TX_CHUNK_RETRY_CAP_BIT];
    assign minChunkPayloadExp =
        cap_reg[MIN_CHUNK_PAYLOAD_EXP_LSB +: MIN_CHUNK_PAYLOAD_EXP_W];

    // =========================================================
    // access decode
    // =========================================================
    // one request in flight at a time: ready drops during the answer cycle
    assign regReady = (accState_reg == ACC_IDLE);
    assign taken = regAccess && regReady;
    assign addrIsCap = (regAddr == FEATURE_CAPABILITY_FLAGS_IDX);
    // unmapped reads answer zero rather than stale data
    assign readMux = addrIsCap ? cap_reg : '0;
    // write data is accepted and dropped; kept only as a named sink
    assign writeSeen = regWdata & '0;

    // =========================================================
    // answer sequencing
    // =========================================================
    always_comb
    begin
        accState_next = accState_reg;
        case (accState_reg)
            ACC_IDLE:
            begin
                if (taken)
                begin
                    accState_next = ACC_ANSWER;
                end
            end
            ACC_ANSWER:
            begin
                accState_next = ACC_IDLE;
            end
            default:
            begin
                accState_next = ACC_IDLE;
            end
        endcase
    end

    // answer contents: mapped reads return the word, unmapped reads zero, writes leave it untouched
    assign done_next = taken;
    assign hit_next = taken ? addrIsCap : 1'b0;
    assign rdata_next = (taken && !regWrite) ? readMux : (rdata_reg | writeSeen);

    // access state kept apart from the answer flops; ready decodes only this
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            accState_reg <= ACC_IDLE;
        end
        else
        begin
            accState_reg <= accState_next;
        end
    end

    // answer strobe and hit flag stand for exactly one cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_reg <= 1'b0;
            hit_reg <= 1'b0;
        end
        else
        begin
            done_reg <= done_next;
            hit_reg <= hit_next;
        end
    end

    // read data holds until the next taken read, so a slow host can still pick it up
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= '0;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign regDone = done_reg;
    assign regHit = hit_reg;
    assign regRdata = rdata_reg;

    // =========================================================
    // chunk payload size supervision
    // =========================================================
    // the host owns the size field; this only reports a misprogramming
    min_chunk_guard #(
        .EXP_W(MIN_CHUNK_PAYLOAD_EXP_W)
    ) u_guard (
        .clk(clk),
        .rst_n(rst_n),
        .minExp(minChunkPayloadExp),
        .cpsField(cpsField),
        .cpsWrite(cpsWrite),
        .belowMin(cpsBelowMin)
    );

endmodule

/* File: tb/capability_regs_monitor.sv */
// assertion checker for the feature capability register block
`timescale 1ns/1ps
module capability_regs_monitor (
    input wire logic clk, // register clock
    input wire logic rst_n, // async reset, active low
    input wire logic regAccess, // request
    input wire logic regWrite, // write select
    input wire logic [capability_pkg::ADDR_W-1:0] regAddr, // index
    input wire logic regReady, // idle
    input wire logic regDone, // answer pulse
    input wire logic regHit, // mapped
    input wire logic [capability_pkg::DATA_W-1:0] regRdata, // read data
    input wire logic [capability_pkg::MIN_CHUNK_PAYLOAD_EXP_W-1:0] cpsField, // exponent
    input wire logic cpsWrite, // field strobe
    input wire logic cpsBelowMin, // too small
    input wire logic txFcsCheckCap, // flag
    input wire logic indirectPhyAccessCap, // flag
    input wire logic directPhyAccessCap, // flag
    input wire logic cutThroughCap, // flag
    input wire logic frameTimestampCap, // flag
    input wire logic addrIncrDisableCap, // flag
    input wire logic txChunkRetryCap, // flag
    input wire logic [capability_pkg::MIN_CHUNK_PAYLOAD_EXP_W-1:0] minChunkPayloadExp // exp
);
    import capability_pkg::*;
    // =========================================================
    // access steps
    // =========================================================
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence takeRead;
        regAccess && regReady && !regWrite;
    endsequence
    sequence takeWrite;
        regAccess && regReady && regWrite;
    endsequence
    sequence takeAny;
        regAccess && regReady;
    endsequence
    a_read_word_value: assert property (takeRead ##0 regAddr == 8'h02 |=>
        regDone && regHit && regRdata == 32'h000006c3) else $error("capability read wrong");
    a_unmapped_read_zero: assert property (takeRead ##0 regAddr != 8'h02 |=>
        regDone && !regHit && regRdata == 32'h0) else $error("unmapped read wrong");
    a_write_drops_data: assert property (takeWrite |=> regDone && $stable(regRdata)
        ##1 !regDone) else $error("write changed read data");
    a_fcs_cap_set: assert property (txFcsCheckCap) else $error("fcs flag low");
    a_phy_access_caps: assert property (indirectPhyAccessCap && !directPhyAccessCap)
        else $error("phy access flags wrong");
    a_cut_stamp_caps: assert property (cutThroughCap && frameTimestampCap)
        else $error("cut or stamp flag low");
    a_incr_retry_off: assert property (!addrIncrDisableCap && !txChunkRetryCap)
        else $error("increment or retry flag high");
    a_min_exp_three: assert property (minChunkPayloadExp == 3'h3) else $error("min exp wrong");
    a_below_min_flag: assert property (cpsWrite |=> cpsBelowMin == ($past(cpsField) < 3'h3))
        else $error("below minimum flag wrong");
    a_ready_after_take: assert property (takeAny |=> !regReady ##1 regReady)
        else $error("ready not low for exactly one cycle");
    a_done_needs_take: assert property (regDone |-> $past(regAccess && regReady))
        else $error("answer without a taken request");
endmodule
bind feature_capability_regs capability_regs_monitor u_mon (.clk(clk), .rst_n(rst_n),
    .regAccess(regAccess), .regWrite(regWrite), .regAddr(regAddr), .regReady(regReady),
    .regDone(regDone), .regHit(regHit), .regRdata(regRdata), .cpsField(cpsField),
    .cpsWrite(cpsWrite), .cpsBelowMin(cpsBelowMin), .txFcsCheckCap(txFcsCheckCap),
    .indirectPhyAccessCap(indirectPhyAccessCap), .directPhyAccessCap(directPhyAccessCap),
    .cutThroughCap(cutThroughCap), .frameTimestampCap(frameTimestampCap),
    .addrIncrDisableCap(addrIncrDisableCap), .txChunkRetryCap(txChunkRetryCap),
    .minChunkPayloadExp(minChunkPayloadExp));

/* File: tb/reg_host_model.sv */
// host model: register requests and chunk size programming
`timescale 1ns/1ps
module reg_host_model (
    input wire logic clk, // register clock
    input wire logic regReady, // device idle
    input wire logic regDone, // answer pulse
    input wire logic regHit, // mapped
    input wire logic [capability_pkg::DATA_W-1:0] regRdata, // read data
    output logic regAccess, // request
    output logic regWrite, // write select
    output logic [capability_pkg::ADDR_W-1:0] regAddr, // index
    output logic [capability_pkg::DATA_W-1:0] regWdata, // write data
    output logic [capability_pkg::MIN_CHUNK_PAYLOAD_EXP_W-1:0] cpsField, // exponent
    output logic cpsWrite // field strobe
);
    import capability_pkg::*;
    initial
    begin
        {regAccess, regWrite, cpsWrite} = 3'h0;
        {regAddr, regWdata, cpsField} = '0;
    end
    // request held to the ready edge; idle address and data lines get inverted so stale values never pass, write select keeps its value
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic hit, output logic ok);
        ok = 1'b0;
        @(posedge clk);
        {regAccess, regWrite, regAddr, regWdata} <= {1'b1, w, a, d};
        for (int n = 0; n < 8 && !ok; n++)
        begin
            @(posedge clk);
            ok = regReady;
        end
        {regAccess, regAddr, regWdata} <= {1'b0, ~a, ~d};
        ok = 1'b0;
        for (int n = 0; n < 4 && !ok; n++)
        begin
            @(posedge clk);
            {ok, rd, hit} = {regDone, regRdata, regHit};
        end
    endtask
    // a careful host never programs under the minimum unless told to
    task automatic program_size(input logic [2:0] f, input logic allowLow, output logic [2:0] used);
        used = (!allowLow && f < 3'h3) ? 3'h3 : f;
        @(posedge clk);
        {cpsField, cpsWrite} <= {used, 1'b1};
        @(posedge clk);
        {cpsField, cpsWrite} <= {~used, 1'b0};
    endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the feature capability register block
`timescale 1ns/1ps
module tb_top;
    import capability_pkg::*;
    logic clk, rst_n, regAccess, regWrite, regReady, regDone, regHit, cpsWrite, cpsBelowMin;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, seed, lastRd;
    logic [2:0] cpsField, minExp, used;
    wire logic [6:0] caps;
    int n_fail, samples_checked;
    feature_capability_regs u_dut (.clk(clk), .rst_n(rst_n), .regAccess(regAccess),
        .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regReady(regReady),
        .regDone(regDone), .regHit(regHit), .regRdata(regRdata), .cpsField(cpsField),
        .cpsWrite(cpsWrite), .cpsBelowMin(cpsBelowMin), .txFcsCheckCap(caps[6]),
        .indirectPhyAccessCap(caps[5]), .directPhyAccessCap(caps[4]), .cutThroughCap(caps[3]),
        .frameTimestampCap(caps[2]), .addrIncrDisableCap(caps[1]), .txChunkRetryCap(caps[0]),
        .minChunkPayloadExp(minExp));
    reg_host_model u_host (.clk(clk), .regReady(regReady), .regDone(regDone), .regHit(regHit),
        .regRdata(regRdata), .regAccess(regAccess), .regWrite(regWrite), .regAddr(regAddr),
        .regWdata(regWdata), .cpsField(cpsField), .cpsWrite(cpsWrite));
    always #2 clk = ~clk;
    // =========================================================
    // helpers
    // =========================================================
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] exp_read(input logic [7:0] a);
        return (a == 8'h02) ? 32'h000006c3 : 32'h0;
    endfunction
    task automatic chk32(input string name, input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", name, e, g);
            n_fail++;
        end
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // writes return the last read value, since they never touch read data
    task automatic do_acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic hit, ok;
        u_host.access(w, a, d, rd, hit, ok);
        chk32("answer", 32'(ok), 32'h1);
        if (!ok)
            give_verdict();
        chk32("hit", 32'(hit), 32'(a == 8'h02));
        chk32("rdata", rd, w ? lastRd : exp_read(a));
        if (!w)
            lastRd = exp_read(a);
    endtask
    initial
    begin
        {clk, rst_n, n_fail, samples_checked, seed, lastRd} = {2'b00, 64'h0, 32'd19, 32'h0};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk32("flags", {21'h0, caps, 1'b0, minExp}, 32'h000006c3);
        do_acc(1'b0, 8'h02, 32'h0);
        do_acc(1'b1, 8'h02, 32'hffffffff);
        do_acc(1'b0, 8'hff, 32'h0);
        do_acc(1'b1, 8'h02, 32'h0);
        do_acc(1'b0, 8'h02, 32'h0);
        for (int i = 0; i < 60; i++)
        begin
            seed = xorshift(seed);
            do_acc(seed[0], seed[1] ? 8'h02 : seed[15:8], seed);
        end
        for (int f = 0; f < 8; f++)
        begin
            u_host.program_size(3'(f), 1'b1, used);
            #1 chk32("below", 32'(cpsBelowMin), 32'(f < 3));
        end
        u_host.program_size(3'h1, 1'b0, used);
        #1 chk32("below", 32'(cpsBelowMin), 32'h0);
        // leave the flag set and read data loaded so the mid-run reset must clear them
        u_host.program_size(3'h0, 1'b1, used);
        #1 chk32("below", 32'(cpsBelowMin), 32'h1);
        do_acc(1'b0, 8'h02, 32'h0);
        @(posedge clk);
        rst_n <= 1'b0;
        #1 chk32("reset rdata", regRdata, 32'h0);
        chk32("reset below", 32'(cpsBelowMin), 32'h0);
        chk32("reset port", {29'h0, regReady, regDone, regHit}, 32'h4);
        chk32("reset flags", {21'h0, caps, 1'b0, minExp}, 32'h000006c3);
        lastRd = 32'h0;
        @(posedge clk);
        rst_n <= 1'b1;
        do_acc(1'b1, 8'h02, 32'h12345678);
        do_acc(1'b0, 8'h02, 32'h0);
        give_verdict();
    end
endmodule
